/* design/avw_defines.vh */
`ifndef AVW_DEFINES_VH
`define AVW_DEFINES_VH

// Register sub-addresses
`define AVW_ADDR_NEXT_LINE_READOUT_START 8'h22
`define AVW_ADDR_START 8'h28
`define AVW_ADDR_STOP 8'h29

// Reset values
`define AVW_RST_NEXT_LINE_READOUT_START 16'h0032
`define AVW_RST_START 16'h003C
`define AVW_RST_STOP 16'h0000

// Writable bits; reserved bits read as zero
`define AVW_MASK_NEXT_LINE_READOUT_START 16'h07FF
`define AVW_MASK_START 16'hF7FF
`define AVW_MASK_STOP 16'hFFFF

// Field positions, start register
`define AVW_VAL_MSB 10
`define AVW_START_GATE 12
`define AVW_START_STD 13
`define AVW_START_PROG 14
`define AVW_START_FLW 15

// Field positions, stop register
`define AVW_STOP_TP_EN 11
`define AVW_STOP_LUMA_LSB 12
`define AVW_STOP_LUMA_MSB 13
`define AVW_STOP_CHROMA_SAMPLING_SELECT 14
`define AVW_STOP_CSEL 15

// Flywheel lines per field, and flywheel vertical blanking lines
`define AVW_LINES_312 10'h138
`define AVW_LINES_262 10'h106
`define AVW_FLW_VBI_LINES 10'h016

// Test pattern levels
`define AVW_Y_LOW 8'h10
`define AVW_Y_MID 8'h5A
`define AVW_Y_HIGH 8'hF0
`define AVW_C_ZERO 8'h80

`endif

/* design/avw_flywheel.v */
`default_nettype none
module avw_flywheel (
  input wire clk_sys,
  input wire srst,
  input wire [10:0] hcount,
  input wire [10:0] line_length,
  input wire std_262,
  input wire progressive,
  output wire vsync_tick,
  output reg field_q,
  output wire [9:0] line_no
);
`include "avw_defines.vh"
  // Counts half lines so that an odd total gives the half-line offset
  reg [10:0] half_q;
  wire [11:0] half_point;
  wire half_tick;
  wire [9:0] lines;
  wire [10:0] last;

  assign half_point = ({1'b0, line_length} + 12'h001) >> 1;
  assign half_tick = (hcount == 11'h000) ||
                     ({1'b0, hcount} == half_point);
  assign lines = std_262 ? `AVW_LINES_262 : `AVW_LINES_312;
  assign last = progressive ? {lines, 1'b0} - 11'h001 :
                {lines, 1'b0};
  assign vsync_tick = half_tick && (half_q >= last);
  assign line_no = half_q[10:1];

  always @(posedge clk_sys) begin
    if (srst) begin
      half_q <= 11'h000;
      field_q <= 1'b0;
    end else if (half_tick) begin
      if (half_q >= last) begin
        half_q <= 11'h000;
        field_q <= progressive ? 1'b0 : ~field_q;
      end else begin
        half_q <= half_q + 11'h001;
      end
    end
  end
endmodule // avw_flywheel
`default_nettype wire

/* design/avw_pattern.v */
`default_nettype none
module avw_pattern (
  input wire clk_sys,
  input wire srst,
  input wire window,
  input wire [10:0] hcount,
  input wire [1:0] luma_sel,
  input wire chroma411,
  input wire chroma_sel,
  output reg [7:0] tp_y,
  output reg [7:0] tp_c
);
`include "avw_defines.vh"
  reg [7:0] ramp_q;
  reg [1:0] phase_q;
  reg [7:0] cb;
  reg [7:0] cr;
  reg [7:0] c_full;

  always @(posedge clk_sys) begin
    if (srst) begin
      ramp_q <= `AVW_Y_LOW;
      phase_q <= 2'h0;
    end else if (!window) begin
      ramp_q <= `AVW_Y_LOW;
      phase_q <= 2'h0;
    end else begin
      // Ramp holds at the top instead of wrapping to black
      if (ramp_q < `AVW_Y_HIGH)
        ramp_q <= ramp_q + 8'h01;
      phase_q <= phase_q + 2'h1;
    end
  end

  // Eight bars across the line
  always @* begin
    case (hcount[9:7])
      3'h0: begin cb = 8'h80; cr = 8'h80; end
      3'h1: begin cb = 8'h10; cr = 8'h92; end
      3'h2: begin cb = 8'hA6; cr = 8'h10; end
      3'h3: begin cb = 8'h36; cr = 8'h22; end
      3'h4: begin cb = 8'hCA; cr = 8'hDE; end
      3'h5: begin cb = 8'h5A; cr = 8'hF0; end
      3'h6: begin cb = 8'hF0; cr = 8'h6E; end
      default: begin cb = 8'h80; cr = 8'h80; end
    endcase
  end

  always @* begin
    case (luma_sel)
      2'h0: tp_y = ramp_q;
      2'h1: tp_y = `AVW_Y_LOW;
      2'h2: tp_y = `AVW_Y_MID;
      default: tp_y = `AVW_Y_HIGH;
    endcase
  end

  always @* begin
    c_full = 8'h00;
    if (luma_sel != 2'h0 || chroma_sel) begin
      tp_c = `AVW_C_ZERO;
    end else if (!chroma411) begin
      tp_c = phase_q[0] ? cr : cb;
    end else begin
      // Two bits of each component per pixel, upper nibble
      case (phase_q)
        2'h0: c_full = {cb[7:6], cr[7:6], 4'h0};
        2'h1: c_full = {cb[5:4], cr[5:4], 4'h0};
        2'h2: c_full = {cb[3:2], cr[3:2], 4'h0};
        default: c_full = {cb[1:0], cr[1:0], 4'h0};
      endcase
      tp_c = c_full;
    end
  end
endmodule // avw_pattern
`default_nettype wire

/* design/avw_timing.v */
// Notes on behaviour
// - Window output goes active when sync counter equals window start value.
// - Window output goes inactive when sync counter equals window stop value.
// - With gating bit set, window held off in blanking and invalid lines.
// - Free-run bit takes vertical timing from internal flywheel, not input.
// - In free run, standard bit picks 312 or 262 lines per field.
// - Progressive bit removes half-line field offset of flywheel.
// - Test pattern enable replaces luma: ramp, 16, 90 or 240.
// - Sampling bit formats test chroma as 4:2:2 or 4:1:1.
// - With ramp luma, chroma bit picks pseudo color bars or zero.
// - Next-line readout starts when sync counter equals next-line value.
// - In one-line scaler bypass, next-line value is ignored.
// - Sync counter runs from zero to line length, then wraps.
`default_nettype none
module avw_timing (
  input wire clk_sys,
  input wire srst,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata_q,
  output reg reg_ack_q,
  input wire [10:0] line_length,
  input wire scaler_bypass_1h,
  input wire in_vsync,
  input wire in_field,
  input wire in_vblank,
  input wire in_line_valid,
  input wire [7:0] in_luma,
  input wire [7:0] in_chroma,
  output reg active_video_window_q,
  output reg next_line_start_q,
  output reg [10:0] sync_count_q,
  output reg vsync_out_q,
  output reg field_out_q,
  output reg vblank_out_q,
  output reg [7:0] out_luma_q,
  output reg [7:0] out_chroma_q
);
`include "avw_defines.vh"

  reg [15:0] next_line_q;
  reg [15:0] start_q;
  reg [15:0] stop_q;
  reg win_raw_q;
  reg win_raw_d;
  reg [10:0] count_d;
  reg [15:0] rdata_d;
  reg blocked;
  reg vblank_sel;
  reg valid_sel;

  wire [10:0] window_start_value;
  wire [10:0] window_stop_value;
  wire [10:0] next_line_value;
  wire window_blank_gating;
  wire freerun_line_standard;
  wire freerun_progressive;
  wire vertical_freerun;
  wire test_pattern_enable;
  wire [1:0] test_luma_select;
  wire chroma_sampling_select;
  wire test_chroma_select;

  wire fly_vsync;
  wire fly_field;
  wire [9:0] fly_line;
  wire [7:0] tp_y;
  wire [7:0] tp_c;

  assign window_start_value = start_q[`AVW_VAL_MSB:0];
  assign window_stop_value = stop_q[`AVW_VAL_MSB:0];
  assign next_line_value = next_line_q[`AVW_VAL_MSB:0];
  assign window_blank_gating = start_q[`AVW_START_GATE];
  assign freerun_line_standard = start_q[`AVW_START_STD];
  assign freerun_progressive = start_q[`AVW_START_PROG];
  assign vertical_freerun = start_q[`AVW_START_FLW];
  assign test_pattern_enable = stop_q[`AVW_STOP_TP_EN];
  assign test_luma_select = stop_q[`AVW_STOP_LUMA_MSB:`AVW_STOP_LUMA_LSB];
  assign chroma_sampling_select = stop_q[`AVW_STOP_CHROMA_SAMPLING_SELECT];
  assign test_chroma_select = stop_q[`AVW_STOP_CSEL];

  // Register writes; reserved bits are never stored
  always @(posedge clk_sys) begin
    if (srst) begin
      next_line_q <= `AVW_RST_NEXT_LINE_READOUT_START;
      start_q <= `AVW_RST_START;
      stop_q <= `AVW_RST_STOP;
    end else if (reg_wr_en) begin
      case (reg_addr)
        `AVW_ADDR_NEXT_LINE_READOUT_START: next_line_q <= reg_wdata & `AVW_MASK_NEXT_LINE_READOUT_START;
        `AVW_ADDR_START: start_q <= reg_wdata & `AVW_MASK_START;
        // Stored as written; host keeps test bits clear in use
        `AVW_ADDR_STOP: stop_q <= reg_wdata & `AVW_MASK_STOP;
        default: ;
      endcase
    end
  end

  // Read back; unmapped sub-addresses answer zero
  always @* begin
    case (reg_addr)
      `AVW_ADDR_NEXT_LINE_READOUT_START: rdata_d = next_line_q;
      `AVW_ADDR_START: rdata_d = start_q;
      `AVW_ADDR_STOP: rdata_d = stop_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata_q <= 16'h0000;
      reg_ack_q <= 1'b0;
    end else begin
      reg_ack_q <= reg_wr_en | reg_rd_en;
      if (reg_rd_en)
        reg_rdata_q <= rdata_d;
    end
  end

  // Sync counter; >= guards against a line length cut below the count
  always @* begin
    if (sync_count_q >= line_length)
      count_d = 11'h000;
    else
      count_d = sync_count_q + 11'h001;
  end

  always @(posedge clk_sys) begin
    if (srst)
      sync_count_q <= 11'h000;
    else
      sync_count_q <= count_d;
  end

  avw_flywheel u_flywheel (
    .clk_sys(clk_sys),
    .srst(srst),
    .hcount(sync_count_q),
    .line_length(line_length),
    .std_262(freerun_line_standard),
    .progressive(freerun_progressive),
    .vsync_tick(fly_vsync),
    .field_q(fly_field),
    .line_no(fly_line)
  );

  // Vertical source selection
  always @* begin
    if (vertical_freerun) begin
      vblank_sel = (fly_line < `AVW_FLW_VBI_LINES);
      valid_sel = 1'b1;
    end else begin
      vblank_sel = in_vblank;
      valid_sel = in_line_valid;
    end
    blocked = window_blank_gating & (vblank_sel | ~valid_sel);
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      vsync_out_q <= 1'b0;
      field_out_q <= 1'b0;
      vblank_out_q <= 1'b0;
    end else begin
      vsync_out_q <= vertical_freerun ? fly_vsync : in_vsync;
      field_out_q <= vertical_freerun ? fly_field : in_field;
      vblank_out_q <= vblank_sel;
    end
  end

  // Stop wins when start and stop coincide
  always @* begin
    if (sync_count_q == window_stop_value)
      win_raw_d = 1'b0;
    else if (sync_count_q == window_start_value)
      win_raw_d = 1'b1;
    else
      win_raw_d = win_raw_q;
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      win_raw_q <= 1'b0;
      active_video_window_q <= 1'b0;
    end else begin
      win_raw_q <= win_raw_d;
      active_video_window_q <= win_raw_d & ~blocked;
    end
  end

  // Next-line readout strobe, one cycle wide
  always @(posedge clk_sys) begin
    if (srst)
      next_line_start_q <= 1'b0;
    else
      next_line_start_q <= ~scaler_bypass_1h &
        (sync_count_q == next_line_value);
  end

  avw_pattern u_pattern (
    .clk_sys(clk_sys),
    .srst(srst),
    .window(win_raw_d),
    .hcount(sync_count_q),
    .luma_sel(test_luma_select),
    .chroma411(chroma_sampling_select),
    .chroma_sel(test_chroma_select),
    .tp_y(tp_y),
    .tp_c(tp_c)
  );

  // Pattern replaces the decoded video, aligned with the window flop
  always @(posedge clk_sys) begin
    if (srst) begin
      out_luma_q <= `AVW_Y_LOW;
      out_chroma_q <= `AVW_C_ZERO;
    end else if (test_pattern_enable) begin
      out_luma_q <= tp_y;
      out_chroma_q <= tp_c;
    end else begin
      out_luma_q <= in_luma;
      out_chroma_q <= in_chroma;
    end
  end

endmodule // avw_timing
`default_nettype wire

/* sim/avw_timing_monitor.sv */
`default_nettype none
module avw_timing_monitor (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [10:0] line_length,
  input wire logic scaler_bypass_1h,
  input wire logic in_vsync,
  input wire logic in_vblank,
  input wire logic in_line_valid,
  input wire logic [7:0] in_luma,
  input wire logic active_video_window_q,
  input wire logic next_line_start_q,
  input wire logic [10:0] sync_count_q,
  input wire logic vsync_out_q,
  input wire logic [7:0] out_luma_q,
  input wire logic [7:0] out_chroma_q
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] nl_q, st_q, sp_q;
  // Shadow copies, so expectations follow host writes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      nl_q <= 16'h0032;
      st_q <= 16'h003C;
      sp_q <= 16'h0000;
    end else if (reg_wr_en) begin
      if (reg_addr == 8'h22) nl_q <= reg_wdata;
      if (reg_addr == 8'h28) st_q <= reg_wdata;
      if (reg_addr == 8'h29) sp_q <= reg_wdata;
    end
  end
  wire logic [10:0] nlv = nl_q[10:0];
  wire logic [10:0] stv = st_q[10:0];
  wire logic [10:0] spv = sp_q[10:0];
  wire logic [7:0] lvl = sp_q[13] ? (sp_q[12] ? 8'hF0 : 8'h5A) : 8'h10;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence one_tick;
    vsync_out_q ##1 !vsync_out_q;
  endsequence
  chk_win_rise: assert property (
    sync_count_q == stv && sync_count_q != spv && !st_q[12]
    |=> active_video_window_q) else $error("window did not open");
  chk_win_fall: assert property (
    sync_count_q == spv |=> !active_video_window_q)
    else $error("window did not close");
  chk_win_gate: assert property (
    st_q[12] && !st_q[15] && (in_vblank || !in_line_valid)
    |=> !active_video_window_q) else $error("window not gated");
  chk_count_wrap: assert property (
    !$past(srst) |=> sync_count_q == ($past(sync_count_q) >=
    $past(line_length) ? 11'h000 : $past(sync_count_q) + 11'h001))
    else $error("sync counter step wrong");
  chk_nl_fire: assert property (
    sync_count_q == nlv && !scaler_bypass_1h |=> next_line_start_q)
    else $error("next line strobe missing");
  chk_nl_only: assert property (
    next_line_start_q |-> $past(sync_count_q) == $past(nlv)
    && !$past(scaler_bypass_1h)) else $error("stray next line strobe");
  chk_vs_pass: assert property (
    !st_q[15] |=> vsync_out_q == $past(in_vsync))
    else $error("input vsync not passed");
  chk_fly_tick: assert property (
    st_q[15] && vsync_out_q |-> one_tick) else $error("tick too long");
  chk_luma_lvl: assert property (
    sp_q[11] && sp_q[13:12] != 2'b00 |=> out_luma_q == $past(lvl))
    else $error("test luma level wrong");
  chk_luma_pass: assert property (
    !sp_q[11] |=> out_luma_q == $past(in_luma))
    else $error("luma not passed");
  chk_chroma_flat: assert property (
    sp_q[11] && (sp_q[13:12] != 2'b00 || sp_q[15])
    |=> out_chroma_q == 8'h80) else $error("test chroma not zero");
endmodule // avw_timing_monitor

bind avw_timing avw_timing_monitor u_mon (
  .clk_sys(clk_sys), .srst(srst), .reg_wr_en(reg_wr_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .line_length(line_length),
  .scaler_bypass_1h(scaler_bypass_1h), .in_vsync(in_vsync),
  .in_vblank(in_vblank), .in_line_valid(in_line_valid),
  .in_luma(in_luma), .active_video_window_q(active_video_window_q),
  .next_line_start_q(next_line_start_q), .sync_count_q(sync_count_q),
  .vsync_out_q(vsync_out_q), .out_luma_q(out_luma_q),
  .out_chroma_q(out_chroma_q)
);
`default_nettype wire

/* sim/avw_backend_model.sv */
`default_nettype none
module avw_backend_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic win,
  input wire logic nl,
  output var logic [10:0] line_px_q,
  output var logic [7:0] nl_cnt_q
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] acc_q;
  // Line total latched on the readout strobe, as a back-end would
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acc_q <= 11'h000;
      line_px_q <= 11'h000;
      nl_cnt_q <= 8'h00;
    end else if (nl) begin
      acc_q <= {10'h000, win};
      line_px_q <= acc_q;
      nl_cnt_q <= nl_cnt_q + 8'h01;
    end else begin
      acc_q <= acc_q + {10'h000, win};
    end
  end
endmodule // avw_backend_model
`default_nettype wire

/* sim/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, srst, wr, rd, byp, ivs, ifld, ivb, ilv;
  logic ack, win, nl, vs, fld, vb;
  logic [7:0] addr, iy, ic, oy, oc, nlc;
  logic [15:0] wd, rdat;
  logic [10:0] llen, cnt, px;
  logic [7:0] ylv [4] = '{8'h00, 8'h10, 8'h5A, 8'hF0};
  int err_total, samples_checked;
  always #2.5 clk_sys = ~clk_sys;
  avw_timing dut (
    .clk_sys(clk_sys), .srst(srst), .reg_wr_en(wr), .reg_rd_en(rd),
    .reg_addr(addr), .reg_wdata(wd), .reg_rdata_q(rdat), .reg_ack_q(ack),
    .line_length(llen), .scaler_bypass_1h(byp), .in_vsync(ivs),
    .in_field(ifld), .in_vblank(ivb), .in_line_valid(ilv), .in_luma(iy),
    .in_chroma(ic), .active_video_window_q(win), .next_line_start_q(nl),
    .sync_count_q(cnt), .vsync_out_q(vs), .field_out_q(fld),
    .vblank_out_q(vb), .out_luma_q(oy), .out_chroma_q(oc)
  );
  avw_backend_model u_be (
    .clk_sys(clk_sys), .srst(srst), .win(win), .nl(nl),
    .line_px_q(px), .nl_cnt_q(nlc)
  );
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    cmp("ack", 16'h0001, {15'h0000, ack});
    cmp("rdata", e, rdat);
  endtask
  // Two full lines, so at least one whole line reaches the back-end
  task automatic chk_line(input logic [10:0] epx, input logic [7:0] enl);
    logic [7:0] n0;
    @(posedge clk_sys);
    #1;
    n0 = nlc;
    repeat (400) @(posedge clk_sys);
    #1;
    cmp("px", {5'h00, epx}, {5'h00, px});
    cmp("nl", {8'h00, enl}, {8'h00, nlc - n0});
    @(posedge clk_sys);
  endtask
  task automatic wait_vs(output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (vs !== 1'b1 && n < 9000);
    if (n >= 9000) begin
      err_total++;
      stop_test();
    end
  endtask
  // Samples two pixels at counts 140 and 141, inside the window and bar 1
  task automatic tp_chk(input logic [15:0] d, input int m);
    logic [7:0] c0, y0;
    int n;
    wreg(8'h29, d);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (cnt !== 11'h08C && n < 400);
    if (n >= 400) begin
      err_total++;
      stop_test();
    end
    @(posedge clk_sys);
    #1;
    c0 = oc;
    y0 = oy;
    @(posedge clk_sys);
    #1;
    if (m == 0) begin
      cmp("ramp", 16'h0001, {8'h00, oy - y0});
      cmp("c422", 16'h0082, {8'h00, c0 ^ oc});
    end else if (m == 1) begin
      cmp("c411", 16'h0000, {12'h000, c0[3:0] | oc[3:0]});
    end else begin
      cmp("czero", 16'h0080, {8'h00, oc});
    end
  endtask
  task automatic fly(input logic [15:0] d, input int per, input logic il);
    int n;
    logic f;
    wreg(8'h28, d);
    wait_vs(n);
    wait_vs(n);
    f = fld;
    wait_vs(n);
    cmp("period", per[15:0], n[15:0]);
    cmp("field", {15'h0000, il ? ~f : 1'b0}, {15'h0000, fld});
  endtask
  initial begin
    clk_sys = 1'b0;
    srst = 1'b1;
    {wr, rd, byp, ivs, ifld, ivb} = 6'h00;
    ilv = 1'b1;
    addr = 8'h00;
    wd = 16'h0000;
    iy = 8'h00;
    ic = 8'h80;
    llen = 11'h0C7;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    rreg(8'h22, 16'h0032);
    rreg(8'h28, 16'h003C);
    rreg(8'h29, 16'h0000);
    rreg(8'h30, 16'h0000);
    wreg(8'h22, 16'hFFFF);
    rreg(8'h22, 16'h07FF);
    wreg(8'h28, 16'hFFFF);
    rreg(8'h28, 16'hF7FF);
    wreg(8'h22, 16'h003C);
    wreg(8'h28, 16'h003C);
    wreg(8'h29, 16'h0096);
    chk_line(11'h05A, 8'h02);
    ivb <= 1'b1;
    chk_line(11'h05A, 8'h02);
    cmp("vblank", 16'h0001, {15'h0000, vb});
    wreg(8'h28, 16'h103C);
    chk_line(11'h000, 8'h02);
    ivb <= 1'b0;
    ilv <= 1'b0;
    chk_line(11'h000, 8'h02);
    ilv <= 1'b1;
    chk_line(11'h05A, 8'h02);
    byp <= 1'b1;
    chk_line(11'h05A, 8'h00);
    byp <= 1'b0;
    for (int s = 1; s < 4; s++) begin
      wreg(8'h29, {2'b00, s[1:0], 12'h896});
      repeat (2) @(posedge clk_sys);
      #1;
      cmp("luma", {8'h00, ylv[s]}, {8'h00, oy});
      cmp("chroma", 16'h0080, {8'h00, oc});
    end
    tp_chk(16'h0896, 0);
    tp_chk(16'h4896, 1);
    tp_chk(16'hC896, 2);
    wreg(8'h29, 16'h0096);
    iy <= 8'h3C;
    repeat (2) @(posedge clk_sys);
    #1;
    cmp("luma", 16'h003C, {8'h00, oy});
    @(posedge clk_sys);
    llen <= 11'h013;
    fly(16'h803C, 625 * 10, 1'b1);
    fly(16'hA03C, 525 * 10, 1'b1);
    fly(16'hE03C, 524 * 10, 1'b0);
    wreg(8'h28, 16'h003C);
    ivs <= 1'b1;
    @(posedge clk_sys);
    #1;
    cmp("vsync", 16'h0001, {15'h0000, vs});
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
